/* File: core/epcirq_top.sv */
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// R01 - External interrupt still fires when its pin is driven as output.
// R02 - External sense selects falling, rising, any change or low level.
// R03 - Low-level sense keeps requesting while the pin stays low.
// R04 - Wake needs two watchdog-clock samples both at the required level.
// R05 - Any change on port B or A3, A6, A7 requests pin-change.
// R06 - High group: B7..B4, A7, A6, A3; low group: B3..B0.
// R07 - A disabled group does not set the pin-change flag.
// R08 - Pins in alternate function are excluded from change detection.
// R09 - Pin-change still fires when the pin is an output.
// R10 - Pin-change detection is independent of the external interrupt; here B6 is excluded while it is enabled on falling sense.
// R11 - B0 masked in two/three-wire serial mode or inverted compare output.
// R12 - Pin mask is OR of its alternate-function enable conditions.
// R13 - Fuse value 0 means programmed, 1 unprogrammed.
// R14 - External flag sets on event, clears on vector or write-one, zero in level mode.
// R15 - Pin-change flag clears on vector or write-one; needs global and enable.
// R16 - Pins pass a synchroniser before edge and change detection.
module epcirq_top (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  i_pb,
	input  wire logic [2:0]  i_pa,
	input  wire logic        i_wdt_clk,
	input  wire logic        i_sleep,
	input  wire logic        i_ack_ext,
	input  wire logic        i_ack_pc,
	output logic             o_irq_ext,
	output logic             o_irq_pc,
	output logic             o_irq,
	output logic             o_wake
);
	////////////////////////////////////////////////////////////////////////////////
	// Bus slave
	logic [7:0]                    mask_q;
	logic [7:0]                    flag_q;
	epcirq_pkg::epcirq_sense_t     sense_q;
	logic [epcirq_pkg::ALT_W-1:0]  alt_q;
	logic [epcirq_pkg::FUSE_W-1:0] fuse_q;
	logic                          wr_pend_q;
	logic [7:0]                    wr_addr_q;
	logic [31:0]                   rdata_q;
	logic                          ext_flag_q;
	logic                          pc_flag_q;

	wire acc      = hsel && hready && (htrans == epcirq_pkg::HTRANS_NONSEQ);
	wire rd_acc   = acc && !hwrite;
	wire wr_mask  = wr_pend_q && (wr_addr_q == epcirq_pkg::ADDR_MASK);
	wire wr_flag  = wr_pend_q && (wr_addr_q == epcirq_pkg::ADDR_FLAG);
	wire wr_sense = wr_pend_q && (wr_addr_q == epcirq_pkg::ADDR_SENSE);
	wire wr_alt   = wr_pend_q && (wr_addr_q == epcirq_pkg::ADDR_ALTCFG);
	wire wr_fuse  = wr_pend_q && (wr_addr_q == epcirq_pkg::ADDR_FUSE);

	epcirq_pkg::epcirq_pins_t lvl;
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = epcirq_pkg::ZERO32;
		unique case (haddr[7:0])
			epcirq_pkg::ADDR_MASK:   rd_mux[7:0] = mask_q;
			epcirq_pkg::ADDR_FLAG:   rd_mux[7:0] = flag_q;
			epcirq_pkg::ADDR_SENSE:  rd_mux[1:0] = sense_q;
			epcirq_pkg::ADDR_ALTCFG: rd_mux[epcirq_pkg::ALT_W-1:0] = alt_q;
			epcirq_pkg::ADDR_FUSE:   rd_mux[epcirq_pkg::FUSE_W-1:0] = fuse_q;
			epcirq_pkg::ADDR_PINS:   rd_mux[epcirq_pkg::NPIN-1:0] = lvl;
			default:                 rd_mux = epcirq_pkg::ZERO32;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h0000_0000;
		end else if (i_ce) begin
			wr_pend_q <= acc && hwrite;
			wr_addr_q <= haddr[7:0];
			if (rd_acc)
				rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mask_q  <= 8'h00;
			sense_q <= epcirq_pkg::SENSE_LOW;
			alt_q   <= '0;
			fuse_q  <= '1;
		end else if (i_ce) begin
			if (wr_mask)
				mask_q <= hwdata[7:0];
			if (wr_sense)
				sense_q <= epcirq_pkg::epcirq_sense_t'(hwdata[1:0]);
			if (wr_alt)
				alt_q <= hwdata[epcirq_pkg::ALT_W-1:0];
			if (wr_fuse)
				fuse_q <= hwdata[epcirq_pkg::FUSE_W-1:0];
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	epcirq_sync u_sync (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_ce   (i_ce),
		.i_pin  ({i_pb, i_pa}),
		.o_lvl  (lvl)
	); // R16

	epcirq_pkg::epcirq_pins_t prev_q;
	logic                     prev_ok_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_q    <= '0;
			prev_ok_q <= 1'b0;
		end else if (i_ce) begin
			prev_q    <= lvl;
			prev_ok_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Alternate-function masks
	wire [4:0] clk_fuse = fuse_q[4:0];
	wire wm_two   = alt_q[epcirq_pkg::ALT_WM_HI];
	wire wm_three = !alt_q[epcirq_pkg::ALT_WM_HI] && alt_q[epcirq_pkg::ALT_WM_LO];
	wire cmp_a    = !alt_q[epcirq_pkg::ALT_CAH] && alt_q[epcirq_pkg::ALT_CAL]
	              && alt_q[epcirq_pkg::ALT_PWMA];
	wire cmp_b    = !alt_q[epcirq_pkg::ALT_CBH] && alt_q[epcirq_pkg::ALT_CBL]
	              && alt_q[epcirq_pkg::ALT_PWMB];
	wire ext_alt  = mask_q[epcirq_pkg::BIT_EXT] && (sense_q == epcirq_pkg::SENSE_FALL);
	wire t0_ext   = alt_q[epcirq_pkg::ALT_T0CS2] && alt_q[epcirq_pkg::ALT_T0CS1];
	wire cmp_off  = !alt_q[epcirq_pkg::ALT_CMPDIS];
	// Fuse bit at 0 counts as programmed
	wire rst_alt  = fuse_q[epcirq_pkg::FUSE_RST] != epcirq_pkg::FUSE_PROG; // R13
	wire x1_alt   = (clk_fuse == epcirq_pkg::CLK_XTAL1_ONLY)
	              || (clk_fuse >= epcirq_pkg::CLK_XTAL1_LO); // R13
	wire x2_alt   = clk_fuse >= epcirq_pkg::CLK_XTAL2_LO; // R13

	epcirq_pkg::epcirq_pins_t amask;
	assign amask.pb[0] = wm_two || wm_three || cmp_a; // R11 R12
	assign amask.pb[1] = wm_three || alt_q[epcirq_pkg::ALT_CAH] || alt_q[epcirq_pkg::ALT_CAL];
	assign amask.pb[2] = wm_two || wm_three || cmp_b; // R12
	assign amask.pb[3] = alt_q[epcirq_pkg::ALT_CBH] || alt_q[epcirq_pkg::ALT_CBL];
	assign amask.pb[4] = x1_alt; // R12
	assign amask.pb[5] = x2_alt;
	assign amask.pb[6] = ext_alt || t0_ext; // R12
	assign amask.pb[7] = rst_alt;
	assign amask.pa[2] = cmp_off;
	assign amask.pa[1] = cmp_off;
	assign amask.pa[0] = alt_q[epcirq_pkg::ALT_REF];

	////////////////////////////////////////////////////////////////////////////////
	// Pin-change detection
	wire hi_en = mask_q[epcirq_pkg::BIT_PC_HI];
	wire lo_en = mask_q[epcirq_pkg::BIT_PC_LO];
	epcirq_pkg::epcirq_pins_t grp_en;
	assign grp_en.pb = {{4{hi_en}}, {4{lo_en}}}; // R06
	assign grp_en.pa = {3{hi_en}}; // R06
	// Pins read as levels regardless of direction, so outputs count too
	wire [10:0] chg = (lvl ^ prev_q) & {11{prev_ok_q}}; // R05 R09
	wire pc_event  = |(chg & grp_en & ~amask); // R07 R08 R10

	////////////////////////////////////////////////////////////////////////////////
	// External interrupt sense on port B bit 6
	wire ext_now  = lvl.pb[6];
	wire ext_prev = prev_q.pb[6];
	logic ext_event;
	always_comb begin
		unique case (sense_q)
			epcirq_pkg::SENSE_LOW:  ext_event = 1'b0;
			epcirq_pkg::SENSE_ANY:  ext_event = prev_ok_q && (ext_now ^ ext_prev);
			epcirq_pkg::SENSE_FALL: ext_event = prev_ok_q && ext_prev && !ext_now;
			epcirq_pkg::SENSE_RISE: ext_event = prev_ok_q && !ext_prev && ext_now;
		endcase
	end // R01 R02 R10
	wire level_mode = sense_q == epcirq_pkg::SENSE_LOW;
	wire level_req  = level_mode && !ext_now; // R03

	////////////////////////////////////////////////////////////////////////////////
	// Flags: set wins over clear
	wire ext_clr = (wr_flag && hwdata[epcirq_pkg::BIT_EXT]) || i_ack_ext;
	wire pc_clr  = (wr_flag && hwdata[epcirq_pkg::BIT_PCF]) || i_ack_pc;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ext_flag_q <= 1'b0;
			pc_flag_q  <= 1'b0;
		end else if (i_ce) begin
			ext_flag_q <= !level_mode && (ext_event || (ext_flag_q && !ext_clr)); // R14
			pc_flag_q  <= pc_event || (pc_flag_q && !pc_clr); // R15
		end
	end
	always_comb begin
		flag_q = 8'h00;
		flag_q[epcirq_pkg::BIT_EXT] = ext_flag_q;
		flag_q[epcirq_pkg::BIT_PCF] = pc_flag_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt requests
	wire gie     = mask_q[epcirq_pkg::BIT_GIE];
	wire ext_req = gie && mask_q[epcirq_pkg::BIT_EXT] && (ext_flag_q || level_req); // R03
	wire pc_req  = gie && (hi_en || lo_en) && pc_flag_q; // R15
	logic irq_ext_q;
	logic irq_pc_q;
	logic irq_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_ext_q <= 1'b0;
			irq_pc_q  <= 1'b0;
			irq_q     <= 1'b0;
		end else if (i_ce) begin
			irq_ext_q <= ext_req;
			irq_pc_q  <= pc_req;
			irq_q     <= ext_req || pc_req;
		end
	end
	assign o_irq_ext = irq_ext_q;
	assign o_irq_pc  = irq_pc_q;
	assign o_irq     = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Wake: two watchdog-clock samples of the requested condition
	logic [2:0] wck_q;
	logic       wake_cnt_q;
	logic       wake_q;
	wire wdt_rise = wck_q[1] && !wck_q[2];
	wire want     = ext_req || (pc_req) || (pc_event && gie);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wck_q      <= 3'h0;
			wake_cnt_q <= 1'b0;
			wake_q     <= 1'b0;
		end else if (i_ce) begin
			wck_q <= {wck_q[1:0], i_wdt_clk};
			if (!i_sleep) begin
				wake_cnt_q <= 1'b0;
				wake_q     <= 1'b0;
			end else if (wdt_rise) begin
				wake_cnt_q <= want;
				wake_q     <= want && wake_cnt_q; // R04
			end
		end
	end
	assign o_wake = wake_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_level_no_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
		level_mode && i_ce |=> !ext_flag_q) else $error("ext flag set in level mode"); // R14
	chk_level_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && level_req && gie && mask_q[epcirq_pkg::BIT_EXT] |=> o_irq_ext)
		else $error("level request dropped"); // R03
	chk_group_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && !pc_flag_q && !hi_en && !lo_en |=> !pc_flag_q)
		else $error("disabled group set flag"); // R07
	chk_mask_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && !pc_flag_q && ((amask | ~grp_en) == 11'h7FF) |=> !pc_flag_q)
		else $error("masked pin set flag"); // R08
	chk_b0_serial: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wm_two |-> amask.pb[0]) else $error("b0 not masked"); // R11
	chk_fall_sets: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && sense_q == epcirq_pkg::SENSE_FALL && ext_event |=> ext_flag_q)
		else $error("falling edge lost"); // R02
	chk_change_sets: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && pc_event |=> pc_flag_q) else $error("pin change lost"); // R05
	chk_pc_gie: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_ce && !gie |=> !o_irq_pc) else $error("pc irq without global enable"); // R15
	chk_wake_two: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_wake) |-> $past(wake_cnt_q)) else $error("wake on one sample"); // R04
endmodule

/* File: core/epcirq_pkg.sv */
package epcirq_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_MASK   = 8'h00;
	localparam logic [7:0] ADDR_FLAG   = 8'h04;
	localparam logic [7:0] ADDR_SENSE  = 8'h08;
	localparam logic [7:0] ADDR_ALTCFG = 8'h0C;
	localparam logic [7:0] ADDR_FUSE   = 8'h10;
	localparam logic [7:0] ADDR_PINS   = 8'h14;
	// Mask and flag register layout
	localparam int BIT_EXT   = 6;
	localparam int BIT_PC_HI = 5;
	localparam int BIT_PC_LO = 4;
	localparam int BIT_GIE   = 0;
	localparam int BIT_PCF   = 5;
	// Alternate-function config register layout
	localparam int ALT_WM_LO  = 0;
	localparam int ALT_WM_HI  = 1;
	localparam int ALT_CAL    = 2;
	localparam int ALT_CAH    = 3;
	localparam int ALT_PWMA   = 4;
	localparam int ALT_CBL    = 5;
	localparam int ALT_CBH    = 6;
	localparam int ALT_PWMB   = 7;
	localparam int ALT_REF    = 8;
	localparam int ALT_CMPDIS = 9;
	localparam int ALT_T0CS1  = 10;
	localparam int ALT_T0CS2  = 11;
	localparam int ALT_W      = 12;
	// Fuse register layout: clock select [4:0], reset disable [5]
	localparam int FUSE_RST = 5;
	localparam int FUSE_W   = 6;
	localparam logic [4:0] CLK_XTAL1_ONLY = 5'h10;
	localparam logic [4:0] CLK_XTAL1_LO   = 5'h15;
	localparam logic [4:0] CLK_XTAL2_LO   = 5'h19;
	localparam logic       FUSE_PROG      = 1'b0;
	localparam int NPIN = 11;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {
		SENSE_LOW  = 2'h0,
		SENSE_ANY  = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} epcirq_sense_t;

	typedef struct packed {
		logic [7:0] pb;
		logic [2:0] pa;
	} epcirq_pins_t;
endpackage

/* File: core/epcirq_sync.sv */
`timescale 1ns/1ps
module epcirq_sync (
	input  wire logic                i_clk,
	input  wire logic                i_nrst,
	input  wire logic                i_ce,
	input  wire logic [10:0]         i_pin,
	output logic      [10:0]         o_lvl
);
	logic [10:0] s1_q;
	logic [10:0] s2_q;
	logic [10:0] s3_q;
	logic [10:0] lvl_q;

	// Three stages; a level is accepted once stages two and three agree
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_q  <= 11'h000;
			s2_q  <= 11'h000;
			s3_q  <= 11'h000;
			lvl_q <= 11'h000;
		end else if (i_ce) begin
			s1_q  <= i_pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end

	assign o_lvl = lvl_q;
endmodule

/* File: sim/epcirq_pins_model.sv */
`timescale 1ns/1ps
module epcirq_pins_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_pb,
	input  wire logic [2:0] i_pa,
	input  wire logic       i_wdt_run,
	output logic      [7:0] o_pb,
	output logic      [2:0] o_pa,
	output logic            o_wdt_clk
);
	// Pins change just after the CPU edge, like a port driven as output
	always @(posedge i_clk) begin
		o_pb <= i_pb;
		o_pa <= i_pa;
	end
	// Watchdog oscillator at 1 us, stands low while stopped
	initial begin
		o_wdt_clk = 1'b0;
		forever begin
			#500;
			o_wdt_clk = i_wdt_run ? ~o_wdt_clk : 1'b0;
		end
	end
endmodule

/* File: sim/test_ext_and_pin_change_irq.sv */
`timescale 1ns/1ps
module test_ext_and_pin_change_irq;
	logic        i_clk = 1'b0, i_nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_q;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  pb_set = 8'h00, i_pb;
	logic [2:0]  i_pa, pa_set = 3'h0;
	logic        i_sleep = 1'b0, i_ack_ext = 1'b0, i_ack_pc = 1'b0, wdt_run = 1'b0;
	logic        i_wdt_clk, rdy_q, o_irq_ext, o_irq_pc, o_irq, o_wake, hreadyout, hresp;
	logic [31:0] hrdata;
	int          n_errors = 0, checks_done = 0, cycles = 0, seed = 32'he2a9;
	logic [7:0]  old_pb, nw;
	logic [1:0]  sense;
	always #12.5 i_clk = ~i_clk;
	epcirq_top u_epcirq_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.i_pb(i_pb), .i_pa(i_pa), .i_wdt_clk(i_wdt_clk), .i_sleep(i_sleep),
		.i_ack_ext(i_ack_ext), .i_ack_pc(i_ack_pc), .o_irq_ext(o_irq_ext),
		.o_irq_pc(o_irq_pc), .o_irq(o_irq), .o_wake(o_wake));
	epcirq_pins_model u_epcirq_pins_model (.i_clk(i_clk), .i_pb(pb_set), .i_pa(pa_set),
		.i_wdt_run(wdt_run), .o_pb(i_pb), .o_pa(i_pa), .o_wdt_clk(i_wdt_clk));
	// Bus answer captured at the sampling edge
	always @(posedge i_clk) begin
		rd_q <= hrdata;
		rdy_q <= hreadyout;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_rdy();
		do begin
			@(posedge i_clk);
			#1;
		end while (rdy_q !== 1'b1);
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		hsize <= epcirq_pkg::HSIZE_WORD;
		htrans <= epcirq_pkg::HTRANS_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		hsel <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, epcirq_pkg::ZERO32);
		chk(what, exp, rd_q);
	endtask
	task automatic pins(input logic [7:0] v);
		@(posedge i_clk);
		pb_set <= v;
		repeat (10) @(posedge i_clk);
		#1;
	endtask
	function automatic logic ext_hit(input logic [1:0] s, input logic a, input logic b);
		case (s)
			epcirq_pkg::SENSE_FALL: ext_hit = a & ~b;
			epcirq_pkg::SENSE_RISE: ext_hit = ~a & b;
			default: ext_hit = a ^ b;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		rd_chk("mask", {24'h0, epcirq_pkg::ADDR_MASK}, 32'h0);
		rd_chk("flag", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h0);
		rd_chk("unmapped", 32'h40, 32'h0);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_MASK}, 32'h1);
		pins(8'h01);
		rd_chk("flag lo off", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h0);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_MASK}, 32'h11);
		for (int i = 0; i < 10; i++) begin
			old_pb = pb_set;
			nw = {4'h0, 4'($random(seed))};
			pins(nw);
			chk("irq_pc", {31'h0, old_pb != nw}, {31'h0, o_irq_pc});
			chk("irq", {31'h0, old_pb != nw}, {31'h0, o_irq});
			if (i[0]) begin
				@(posedge i_clk);
				i_ack_pc <= 1'b1;
				@(posedge i_clk);
				i_ack_pc <= 1'b0;
			end else begin
				bus(1'b1, {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h20);
			end
			rd_chk("flag clr", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h0);
		end
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_ALTCFG}, 32'h1 << epcirq_pkg::ALT_WM_HI);
		pins(pb_set ^ 8'h01);
		rd_chk("b0 masked", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h0);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_ALTCFG}, 32'h1 << epcirq_pkg::ALT_CMPDIS);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_MASK}, 32'h21);
		pa_set <= 3'h5;
		pins(pb_set);
		rd_chk("pa change", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h20);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h20);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_ALTCFG}, 32'h0);
		pins(8'h00);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h60);
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_MASK}, 32'h61);
		for (int m = 1; m < 4; m++) begin
			sense = 2'(m);
			bus(1'b1, {24'h0, epcirq_pkg::ADDR_SENSE}, {30'h0, sense});
			repeat (2) begin
				old_pb = pb_set;
				pins(pb_set ^ 8'h40);
				rd_chk("ext pc flags", {24'h0, epcirq_pkg::ADDR_FLAG},
					{25'h0, ext_hit(sense, old_pb[6], pb_set[6]),
					sense != epcirq_pkg::SENSE_FALL, 5'h0});
				chk("irq_ext", {31'h0, ext_hit(sense, old_pb[6], pb_set[6])},
					{31'h0, o_irq_ext});
				bus(1'b1, {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h60);
			end
		end
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_SENSE}, 32'h0);
		pins(8'h00);
		repeat (20) @(posedge i_clk);
		#1;
		chk("level irq", 32'h1, {31'h0, o_irq_ext});
		bus(1'b1, {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h20);
		rd_chk("level flag", {24'h0, epcirq_pkg::ADDR_FLAG}, 32'h0);
		chk("no wake", 32'h0, {31'h0, o_wake});
		i_sleep <= 1'b1;
		wdt_run <= 1'b1;
		repeat (250) @(posedge i_clk);
		#1;
		chk("wake", 32'h1, {31'h0, o_wake});
		conclude();
	end
endmodule
